// ---- verilog/adr_regs.sv ----
`timescale 1ns/1ps
`include "adr_params.svh"
module adr_regs #(
  parameter int unsigned UNIT_CYCLES = `ADR_UNIT_MS * (`ADR_CLK_HZ / 1000)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // asynchronous condition pins
  input wire logic id_line_shorted_i,
  input wire logic bus_overcurrent_i,
  input wire logic bus_overvoltage_i,
  input wire logic microphone_overvoltage_i,
  input wire logic id_line_floating_i,
  input wire logic bus_supply_valid_i,
  input wire logic charge_detect_active_i,
  input wire logic data_contact_detected_i,
  input wire logic charge_detect_done_i,
  input wire logic [4:0] id_line_code_i,
  // outputs
  output logic id_measure_en_o,
  output logic irq_o
);
  // ----------------------------------------
  // constants and helpers
  // ----------------------------------------
  localparam logic [`ADR_PRE_W-1:0] PRE_LAST = `ADR_PRE_W'(UNIT_CYCLES - 1);

  localparam adr_pkg::adr_state_s ST_RST = '{
    pin_s1: 8'h00, pin_s2: 8'h00, pin_s3: 8'h00,
    done_s1: 1'b0, done_s2: 1'b0, done_s3: 1'b0,
    code_s1: 5'h00, code_s2: 5'h00, code: 5'h00,
    flags: `ADR_RST_EVT, mask: `ADR_RST_MASK, timing: `ADR_RST_TIME,
    dis: `ADR_RST_DIS, gmask: `ADR_RST_GMASK, wait_r: 1'b1,
    rdata: 8'h00, irq: 1'b0, meas: adr_pkg::ADR_MS_RUN,
    pre: '0, unit: 5'h00
  };

  // window length in 50 ms units
  function automatic logic [4:0] adr_units(input logic [3:0] c);
    if (c <= `ADR_TSTEP_LAST) begin
      adr_units = {1'b0, c} + 5'h01;
    end else if (c <= `ADR_TCODE_LAST) begin
      adr_units = {c, 1'b0} - 5'h02;
    end else begin
      adr_units = `ADR_UNITS_MAX;
    end
  endfunction

  adr_pkg::adr_state_s q;
  adr_pkg::adr_state_s d;
  logic [7:0] pins;
  logic [7:0] ev;
  logic [7:0] clr;
  logic [7:0] stat;
  logic [7:0] rmux;
  logic [5:0] idx;
  logic aligned;
  logic [4:0] tgt;
  logic [4:0] newc;
  logic evt_read;
  logic win_end;

  // ----------------------------------------
  // combinational next state
  // ----------------------------------------
  always_comb begin
    pins = {id_line_shorted_i, bus_overcurrent_i, bus_overvoltage_i,
            microphone_overvoltage_i, id_line_floating_i, bus_supply_valid_i,
            charge_detect_active_i, data_contact_detected_i};
    d = q;
    ev = 8'h00;
    clr = 8'h00;
    rmux = 8'h00;
    newc = q.code_s2;
    idx = avs_address_i[7:2];
    aligned = (avs_address_i[1:0] == 2'b00);
    tgt = adr_units(q.timing);
    evt_read = 1'b0;
    // window end, also read by the checks below
    win_end = (q.meas == adr_pkg::ADR_MS_RUN) && (q.pre == PRE_LAST)
              && (q.unit >= tgt - 5'h01);
    // two-stage synchronisers, third stage for edges
    d.pin_s1 = pins;
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    d.code_s1 = id_line_code_i;
    d.code_s2 = q.code_s1;
    // done is a pulse: only its rising edge counts
    d.done_s1 = charge_detect_done_i;
    d.done_s2 = q.done_s1;
    d.done_s3 = q.done_s2;
    ev[`ADR_B_OCP] = q.pin_s2[`ADR_B_OCP] ^ q.pin_s3[`ADR_B_OCP];
    ev[`ADR_B_OVP] = q.pin_s2[`ADR_B_OVP] ^ q.pin_s3[`ADR_B_OVP];
    ev[`ADR_B_MIC] = q.pin_s2[`ADR_B_MIC] ^ q.pin_s3[`ADR_B_MIC];
    ev[`ADR_B_VBUS] = q.pin_s2[`ADR_B_VBUS] ^ q.pin_s3[`ADR_B_VBUS];
    ev[`ADR_B_DONE] = q.done_s2 & ~q.done_s3;
    // ----------------------------------------
    // id measurement window
    // ----------------------------------------
    case (q.meas)
      adr_pkg::ADR_MS_RUN: begin
        if (q.pre == PRE_LAST) begin
          d.pre = '0;
          if (q.unit >= tgt - 5'h01) begin
            d.unit = 5'h00;
            d.code = newc;
            if (newc != q.code) begin
              // zero always reported so a lost accessory is never missed
              ev[`ADR_B_CODE] = !q.dis || (newc == 5'h00);
            end
            if (q.dis && (newc != 5'h00)) begin
              d.meas = adr_pkg::ADR_MS_HOLD;
            end
          end else begin
            d.unit = q.unit + 5'h01;
          end
        end else begin
          d.pre = q.pre + `ADR_PRE_W'(1);
        end
      end
      adr_pkg::ADR_MS_HOLD: begin
        d.pre = '0;
        d.unit = 5'h00;
        if (q.pin_s2[`ADR_B_FLOAT]) begin
          d.code = 5'h00;
          ev[`ADR_B_CODE] = 1'b1;
          d.meas = adr_pkg::ADR_MS_RUN;
        end else if (!q.dis) begin
          d.meas = adr_pkg::ADR_MS_RUN;
        end
      end
      default: begin
        d.meas = adr_pkg::ADR_MS_RUN;
      end
    endcase
    // ----------------------------------------
    // live status
    // ----------------------------------------
    stat = q.pin_s2;
    stat[`ADR_B_FLOAT] = (q.code != 5'h00);
    // ----------------------------------------
    // register read mux
    // ----------------------------------------
    if (!aligned) begin
      rmux = 8'h00;
    end else if (idx == `ADR_IDX_CTRL) begin
      rmux[`ADR_B_DIS] = q.dis;
      rmux[`ADR_B_GMASK] = q.gmask;
    end else if (idx == `ADR_IDX_EVT) begin
      rmux = q.flags & `ADR_EVT_USED;
      evt_read = 1'b1;
    end else if (idx == `ADR_IDX_MASK) begin
      rmux = q.mask & `ADR_EVT_USED;
    end else if (idx == `ADR_IDX_CODE) begin
      rmux = {3'b000, q.code};
    end else if (idx == `ADR_IDX_TIME) begin
      rmux = {4'h0, q.timing};
    end else if (idx == `ADR_IDX_STAT) begin
      rmux = stat;
    end
    // ----------------------------------------
    // bus handshake: one wait cycle, then ack
    // ----------------------------------------
    if (q.wait_r) begin
      if (avs_read_i || avs_write_i) begin
        d.wait_r = 1'b0;
        d.rdata = avs_read_i ? rmux : 8'h00;
      end
    end else begin
      d.wait_r = 1'b1;
      if (avs_write_i && avs_byteenable_i[0] && aligned) begin
        if (idx == `ADR_IDX_CTRL) begin
          d.dis = avs_writedata_i[`ADR_B_DIS];
          d.gmask = avs_writedata_i[`ADR_B_GMASK];
        end else if (idx == `ADR_IDX_MASK) begin
          d.mask = avs_writedata_i[7:0] & `ADR_EVT_USED;
        end else if (idx == `ADR_IDX_TIME) begin
          d.timing = avs_writedata_i[3:0];
        end
      end
      if (avs_read_i && evt_read) begin
        // clear only what was returned; later events survive
        clr = q.rdata;
      end
    end
    // set wins over clear
    d.flags = ((q.flags & ~clr) | ev) & `ADR_EVT_USED;
    d.irq = (|(d.flags & ~d.mask)) && !d.gmask;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= ST_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign avs_readdata_o = {24'h000000, q.rdata};
  assign avs_waitrequest_o = q.wait_r;
  assign irq_o = q.irq;
  assign id_measure_en_o = q.meas[0];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_EVT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !q.wait_r && avs_read_i && aligned && idx == `ADR_IDX_EVT)
    |=> q.flags == (($past(q.flags) & ~$past(q.rdata)) | $past(ev)))
    else $error("event bits not cleared by read");

  AST_OCP_EVT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && (q.pin_s2[`ADR_B_OCP] != q.pin_s3[`ADR_B_OCP])) |=> q.flags[`ADR_B_OCP])
    else $error("over-current change lost");

  AST_OVP_EVT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && $changed(q.pin_s2[`ADR_B_OVP])) ##1 ce_i |=> q.flags[`ADR_B_OVP])
    else $error("over-voltage change lost");

  AST_MIC_EVT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && (q.pin_s2[`ADR_B_MIC] != q.pin_s3[`ADR_B_MIC])) |=> q.flags[`ADR_B_MIC])
    else $error("microphone change lost");

  AST_VBUS_EVT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && (q.pin_s2[`ADR_B_VBUS] != q.pin_s3[`ADR_B_VBUS])) |=> q.flags[`ADR_B_VBUS])
    else $error("supply valid change lost");

  AST_DONE_EVT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && q.done_s2 && !q.done_s3) |=> q.flags[`ADR_B_DONE] && !q.flags[7] && !q.flags[0])
    else $error("detection done event wrong");

  AST_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_o == ((|(q.flags & ~q.mask)) && !q.gmask))
    else $error("interrupt output mismatch");

  AST_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.meas == adr_pkg::ADR_MS_HOLD) |-> (!id_measure_en_o && q.code != 5'h00))
    else $error("hold state without detected resistor");

  AST_FLOAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && q.meas == adr_pkg::ADR_MS_HOLD && q.pin_s2[`ADR_B_FLOAT])
    |=> (q.code == 5'h00) && q.flags[`ADR_B_CODE] && id_measure_en_o)
    else $error("float during hold not reported");

  AST_PRESCALE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.pre <= PRE_LAST) && (q.unit <= `ADR_UNITS_MAX))
    else $error("window counter out of range");

  AST_EVT_RD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && q.wait_r && avs_read_i && aligned && idx == `ADR_IDX_EVT)
    |=> avs_readdata_o == {24'h000000, $past(q.flags)})
    else $error("event read data wrong");

  AST_EVT_RSVD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.flags & ~`ADR_EVT_USED) == 8'h00)
    else $error("unused event bit set");

  AST_MASK_RSVD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.mask & ~`ADR_EVT_USED) == 8'h00)
    else $error("unused mask bit set");

  AST_CODE_RD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && q.wait_r && avs_read_i && aligned && idx == `ADR_IDX_CODE)
    |=> avs_readdata_o == {27'h0000000, $past(q.code)})
    else $error("code read data wrong");

  AST_TIME_RD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && q.wait_r && avs_read_i && aligned && idx == `ADR_IDX_TIME)
    |=> avs_readdata_o == {28'h0000000, $past(q.timing)})
    else $error("timing read data wrong");

  AST_STAT_RD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && q.wait_r && avs_read_i && aligned && idx == `ADR_IDX_STAT)
    |=> avs_readdata_o == {24'h000000, $past(q.pin_s2[`ADR_B_SHORT:`ADR_B_MIC]),
    $past(q.code != 5'h00), $past(q.pin_s2[`ADR_B_VBUS:`ADR_B_DCD])})
    else $error("status read data wrong");

  AST_SUPPRESS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.dis && q.meas == adr_pkg::ADR_MS_RUN && q.code_s2 != 5'h00) |-> !ev[`ADR_B_CODE])
    else $error("code change reported while redetect disabled");

  AST_CODE_EVT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && win_end && !q.dis && q.code_s2 != q.code) |=> q.flags[`ADR_B_CODE])
    else $error("code change lost");

  AST_ZERO_CODE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && win_end && q.code != 5'h00 && q.code_s2 == 5'h00)
    |=> (q.code == 5'h00) && q.flags[`ADR_B_CODE])
    else $error("drop to zero code not reported");

  AST_WIN_LAST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.timing == `ADR_TCODE_LAST) |-> (tgt == `ADR_UNITS_MAX))
    else $error("longest defined window wrong");

  AST_UNDEF_TIME: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.timing > `ADR_TCODE_LAST) |-> (tgt == `ADR_UNITS_MAX))
    else $error("undefined timing code not clamped");

  AST_GMASK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    q.gmask |-> !irq_o)
    else $error("interrupt raised while globally masked");

  AST_MEAS_EN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.meas == adr_pkg::ADR_MS_RUN) |-> id_measure_en_o)
    else $error("measurement enable low while running");

  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

endmodule // adr_regs

// ---- verilog/adr_params.svh ----
`ifndef ADR_PARAMS_SVH
`define ADR_PARAMS_SVH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define ADR_IDX_CTRL 6'h02
`define ADR_IDX_EVT 6'h03
`define ADR_IDX_MASK 6'h05
`define ADR_IDX_CODE 6'h07
`define ADR_IDX_TIME 6'h08
`define ADR_IDX_STAT 6'h09
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define ADR_B_SHORT 7
`define ADR_B_OCP 6
`define ADR_B_OVP 5
`define ADR_B_MIC 4
`define ADR_B_FLOAT 3
`define ADR_B_CODE 3
`define ADR_B_VBUS 2
`define ADR_B_ACT 1
`define ADR_B_DONE 1
`define ADR_B_DCD 0
`define ADR_B_PDONE 3
`define ADR_B_DIS 5
`define ADR_B_GMASK 0
`define ADR_EVT_USED 8'h7E
`define ADR_RST_EVT 8'h00
`define ADR_RST_MASK 8'h00
`define ADR_RST_TIME 4'h0
`define ADR_RST_DIS 1'b1
`define ADR_RST_GMASK 1'b1
// ----------------------------------------
// timing
// ----------------------------------------
`define ADR_CLK_HZ 25000000
`define ADR_UNIT_MS 50
`define ADR_PRE_W 24
`define ADR_TSTEP_LAST 4'h3
`define ADR_TCODE_LAST 4'hB
`define ADR_UNITS_MAX 5'h14
`endif

// ---- verilog/adr_pkg.sv ----
`include "adr_params.svh"
package adr_pkg;
  typedef enum logic [1:0] {
    ADR_MS_RUN = 2'b01,
    ADR_MS_HOLD = 2'b10
  } adr_meas_e;

  typedef struct packed {
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic [4:0] code_s1;
    logic [4:0] code_s2;
    logic [4:0] code;
    logic [7:0] flags;
    logic [7:0] mask;
    logic [3:0] timing;
    logic dis;
    logic gmask;
    logic wait_r;
    logic [7:0] rdata;
    logic irq;
    adr_meas_e meas;
    logic [`ADR_PRE_W-1:0] pre;
    logic [4:0] unit;
  } adr_state_s;
endpackage

// ---- test/adr_host.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// host register bus master
// ----------------------------------------
module adr_host (
  // clock
  input wire logic clk_i,
  // avalon-mm master
  input wire logic wait_i,
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o
);
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    be_o = 4'h0;
    wdata_o = 32'h0;
  end

  // request held until the edge that sees waitrequest low; no cycle count assumed
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= !w;
    wr_o <= w;
    be_o <= 4'hF;
    wdata_o <= {24'h0, d};
    @(posedge clk_i);
    while (wait_i !== 1'b0) @(posedge clk_i);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
  endtask
endmodule // adr_host

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wt;
  logic rd;
  logic wr;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [8:0] pin = 9'h000;
  logic [4:0] code = 5'h00;
  logic meas_en;
  logic irq;
  logic [31:0] q[$];
  logic [7:0] rv;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  always #20 clk_i = ~clk_i;

  adr_host host_u (.clk_i(clk_i), .wait_i(wt), .addr_o(addr), .rd_o(rd), .wr_o(wr),
    .be_o(be), .wdata_o(wdat));

  adr_regs #(.UNIT_CYCLES(4)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .id_line_shorted_i(pin[8]), .bus_overcurrent_i(pin[7]), .bus_overvoltage_i(pin[6]),
    .microphone_overvoltage_i(pin[5]), .id_line_floating_i(pin[4]),
    .bus_supply_valid_i(pin[3]), .charge_detect_active_i(pin[2]),
    .data_contact_detected_i(pin[1]), .charge_detect_done_i(pin[0]),
    .id_line_code_i(code), .id_measure_en_o(meas_en), .irq_o(irq));

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // levels looked at mid-cycle, away from the edge that launches them
  task automatic chk_lvl(input logic [1:0] e);
    @(negedge clk_i);
    chk({30'h0, e}, {30'h0, irq, meas_en});
    @(posedge clk_i);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic rdr(input logic [7:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    host_u.acc(a, 1'b0, 8'h00);
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    host_u.acc(a, 1'b1, d);
  endtask

  // ----------------------------------------
  // read result watcher
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rd === 1'b1 && wt === 1'b0) chk(q.pop_front(), rdat);
  end

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(62245));
    cyc(10);
    rst_n_i <= 1'b1;
    rdr(8'h0C, 8'h00);
    rdr(8'h14, 8'h00);
    rdr(8'h1C, 8'h00);
    rdr(8'h20, 8'h00);
    rdr(8'h24, 8'h00);
    rdr(8'h08, 8'h21);
    wrr(8'h3C, 8'hFF);
    rdr(8'h3C, 8'h00);
    rdr(8'h0D, 8'h00);
    $display("reset values done");
    rv = 8'($urandom);
    wrr(8'h14, rv);
    rdr(8'h14, rv & 8'h7E);
    rv = 8'($urandom);
    wrr(8'h20, rv);
    rdr(8'h20, rv & 8'h0F);
    wrr(8'h20, 8'h00);
    wrr(8'h14, 8'h00);
    $display("read write done");
    pin <= 9'h1EE;
    cyc(8);
    rdr(8'h24, 8'hF7);
    chk_lvl(2'b01);
    rdr(8'h0C, 8'h74);
    rdr(8'h0C, 8'h00);
    pin[7] <= 1'b0;
    cyc(8);
    rdr(8'h0C, 8'h40);
    $display("condition events done");
    wrr(8'h08, 8'h00);
    pin[0] <= 1'b1;
    cyc(4);
    pin[0] <= 1'b0;
    cyc(6);
    chk_lvl(2'b11);
    rdr(8'h0C, 8'h02);
    cyc(2);
    chk_lvl(2'b01);
    wrr(8'h14, 8'h02);
    pin[0] <= 1'b1;
    cyc(4);
    pin[0] <= 1'b0;
    cyc(6);
    chk_lvl(2'b01);
    rdr(8'h0C, 8'h02);
    wrr(8'h14, 8'h00);
    $display("interrupt done");
    code <= 5'h05;
    cyc(30);
    rdr(8'h0C, 8'h08);
    rdr(8'h1C, 8'h05);
    rdr(8'h24, 8'hBF);
    wrr(8'h08, 8'h20);
    cyc(30);
    chk_lvl(2'b00);
    pin[4] <= 1'b1;
    code <= 5'h00;
    cyc(30);
    rdr(8'h0C, 8'h08);
    rdr(8'h1C, 8'h00);
    pin[4] <= 1'b0;
    cyc(4);
    code <= 5'h07;
    cyc(30);
    rdr(8'h0C, 8'h00);
    rdr(8'h1C, 8'h07);
    rv = 8'h0B + 8'($urandom % 5);
    wrr(8'h20, rv);
    code <= 5'h0A;
    wrr(8'h08, 8'h00);
    cyc(60);
    rdr(8'h1C, 8'h07);
    cyc(30);
    rdr(8'h1C, 8'h0A);
    rdr(8'h0C, 8'h08);
    $display("detection time done");
    $display("resistor code done");
    cyc(2);
    chk(32'h0, q.size());
    give_verdict();
  end
endmodule // testbench
